// ==== plm_checker_assertions.sv ====
// checker: bus, startup, interrupt and lock relations seen at the block's ports
`timescale 1ns/1ns
module plm_checker
  import plm_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = 50
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [23:0] meas_error_ppb,
  input wire logic oscillator_power_mode,
  input wire logic osc_settled,
  input wire logic pll_locked,
  input wire logic irq
);
  // nominal limits per selector code, in ppb
  localparam logic [23:0] LIM [8] = '{PLM_LIM0, PLM_LIM1, PLM_LIM2, PLM_LIM3,
                                     PLM_LIM4, PLM_LIM5, PLM_LIM6, PLM_LIM7};
  logic wr_p; // write data phase pending
  logic [7:0] wr_i; // word index of the last address phase
  logic [7:0] ctl_q; // shadow of the monitor control word
  logic [7:0] msk_q; // shadow of the interrupt mask
  logic skip_q; // settle wait skip was written
  int unsigned cyc; // edges since reset release
  ////////////////////////////////////////////////////////////////////////////
  // shadows follow the writes seen on the bus
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_p <= 1'b0;
      wr_i <= 8'h00;
      ctl_q <= PLM_LOCKCTL_RST;
      msk_q <= 8'h00;
      skip_q <= 1'b0;
      cyc <= 0;
    end else begin
      wr_p <= hsel && hready && htrans[1] && hwrite;
      wr_i <= haddr[9:2];
      cyc <= cyc + 1;
      if (wr_p && wr_i == PLM_IDX_LOCKCTL) ctl_q <= hwdata[7:0];
      if (wr_p && wr_i == PLM_IDX_IRQ_MASK) msk_q <= hwdata[7:0];
      if (wr_p && wr_i == PLM_IDX_SUPPLY && hwdata[PLM_B_SKIP]) skip_q <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_power_follows: assert property (
    wr_p && wr_i == PLM_IDX_SUPPLY |=> oscillator_power_mode == $past(hwdata[PLM_B_POWER]))
    else $error("power mode does not follow write");
  a_settle_early: assert property (
    $rose(osc_settled) |-> skip_q || (cyc >= SETTLE_CYC && cyc <= SETTLE_CYC + 2))
    else $error("settle ended at wrong time");
  a_settle_late: assert property (cyc == SETTLE_CYC + 3 |-> osc_settled)
    else $error("settle wait overran");
  a_settle_sticky: assert property (osc_settled |=> osc_settled)
    else $error("settle flag dropped");
  a_lock_rise: assert property (
    $rose(pll_locked) |-> $past(meas_error_ppb) <= LIM[ctl_q[3:1]] + (LIM[ctl_q[3:1]] >> 2))
    else $error("lock with error above limit");
  a_lock_fall: assert property (
    $fell(pll_locked) |-> $past(meas_error_ppb) > LIM[ctl_q[3:1]] - (LIM[ctl_q[3:1]] >> 2))
    else $error("unlock with error below limit");
  a_idle_hold: assert property (
    !ctl_q[PLM_B_RUN] || ctl_q[PLM_B_DISABLE] |=> $stable(pll_locked))
    else $error("lock changed while idle");
  a_meas_settled: assert property ($changed(pll_locked) |-> osc_settled)
    else $error("measurement before settle");
  a_irq_masked: assert property (irq |-> msk_q != 8'h00 || $past(msk_q) != 8'h00)
    else $error("interrupt with empty mask");
endmodule // plm_checker

bind plm_lock_monitor plm_checker #(.SETTLE_CYC(SETTLE_CYC)) i_chk (
  .core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .meas_error_ppb(meas_error_ppb),
  .oscillator_power_mode(oscillator_power_mode), .osc_settled(osc_settled),
  .pll_locked(pll_locked), .irq(irq)
);

// ==== plm_lock_monitor.sv ====
// module: oscillator power control and frequency-error lock monitor with ahb-lite registers
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ns
module plm_lock_monitor
  import plm_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = PLM_SETTLE_S * 1000 * PLM_CLK_PER_MS,
  parameter int unsigned INTV0_CYC = PLM_T0_MS * PLM_CLK_PER_MS,
  parameter int unsigned INTV1_CYC = PLM_T1_MS * PLM_CLK_PER_MS,
  parameter int unsigned INTV2_CYC = PLM_T2_MS * PLM_CLK_PER_MS,
  parameter int unsigned INTV3_CYC = PLM_T3_MS * PLM_CLK_PER_MS,
  parameter int unsigned INTV4_CYC = PLM_T4_US * PLM_CLK_PER_US,
  parameter int unsigned INTV5_CYC = PLM_T5_US * PLM_CLK_PER_US
) (
  input wire logic core_clk,
  input wire logic rst_b,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // measured frequency error from the phase detector, in ppb
  input wire logic [23:0] meas_error_ppb,
  // oscillator controls and status
  output logic oscillator_power_mode,
  output logic osc_settled,
  output logic pll_locked,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  // control registers
  logic skip_regulator_settle_wait; // supply register bit 1
  logic lock_monitor_run; // live run bit
  logic [2:0] lock_error_limit_sel; // threshold and interval selector
  logic lock_monitor_disable; // live disable bit
  // readback state
  logic [9:0] freq_error_magnitude; // saturated error value
  logic error_unit_select; // 0 ppb, 1 ppm
  logic lock_measure_complete; // a measurement has finished
  // interrupt registers
  logic [2:0] irq_stat; // sticky events
  logic [2:0] irq_mask; // 1 lets the event reach irq
  // startup wait
  plm_state_t state;
  plm_state_t next_state;
  logic [24:0] settle_cnt; // cycles spent waiting
  // measurement timing
  logic [24:0] intv_cnt; // cycles into current interval
  logic [2:0] sel_seen; // selector of the running interval
  // ahb address phase capture
  logic wr_pend; // write data phase pending
  logic [7:0] wr_idx; // register index of the pending write

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  // a valid transfer is a selected nonsequential or sequential phase
  wire addr_ok = hsel && hready && htrans[1];
  // word index of the access
  wire [7:0] acc_idx = haddr[9:2];
  wire rd_req = addr_ok && !hwrite;
  // write strobes in the data phase
  wire wr_supply = wr_pend && (wr_idx == PLM_IDX_SUPPLY);
  wire wr_lockctl = wr_pend && (wr_idx == PLM_IDX_LOCKCTL);
  wire wr_stat = wr_pend && (wr_idx == PLM_IDX_IRQ_STAT);
  wire wr_mask = wr_pend && (wr_idx == PLM_IDX_IRQ_MASK);

  // register images, reserved bits read as zero
  wire [7:0] supply_img = {6'h00, skip_regulator_settle_wait, oscillator_power_mode};
  wire [7:0] lockctl_img = {3'h0, lock_monitor_run, lock_error_limit_sel,
                            lock_monitor_disable};
  wire [7:0] err_lo_img = freq_error_magnitude[7:0];
  wire [7:0] err_hi_img = {3'h0, lock_measure_complete, error_unit_select, pll_locked,
                           freq_error_magnitude[9:8]}; // [R12] [R13] [R14] [R15]

  // read mux, unmapped words read as zero
  wire [7:0] rd_byte =
      (acc_idx == PLM_IDX_SUPPLY) ? supply_img :
      (acc_idx == PLM_IDX_LOCKCTL) ? lockctl_img :
      (acc_idx == PLM_IDX_ERR_LO) ? err_lo_img :
      (acc_idx == PLM_IDX_ERR_HI) ? err_hi_img :
      (acc_idx == PLM_IDX_IRQ_STAT) ? {5'h00, irq_stat} :
      (acc_idx == PLM_IDX_IRQ_MASK) ? {5'h00, irq_mask} : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // interval and limit selection

  // update interval in cycles for each selector code
  wire [24:0] intv_tab [8];
  assign intv_tab[0] = 25'(INTV0_CYC); // [R6]
  assign intv_tab[1] = 25'(INTV1_CYC);
  assign intv_tab[2] = 25'(INTV2_CYC);
  assign intv_tab[3] = 25'(INTV3_CYC);
  assign intv_tab[4] = 25'(INTV4_CYC); // [R7]
  assign intv_tab[5] = 25'(INTV5_CYC);
  assign intv_tab[6] = 25'(PLM_T6_US * PLM_CLK_PER_US);
  assign intv_tab[7] = 25'(PLM_T7_US * PLM_CLK_PER_US);
  // error limit in ppb for each selector code
  wire [23:0] lim_tab [8];
  assign lim_tab[0] = PLM_LIM0; // [R6]
  assign lim_tab[1] = PLM_LIM1;
  assign lim_tab[2] = PLM_LIM2;
  assign lim_tab[3] = PLM_LIM3;
  assign lim_tab[4] = PLM_LIM4; // [R7]
  assign lim_tab[5] = PLM_LIM5;
  assign lim_tab[6] = PLM_LIM6;
  assign lim_tab[7] = PLM_LIM7;

  // detector runs only when run is set, disable clear and oscillator settled
  wire meas_active = lock_monitor_run && !lock_monitor_disable
                     && (state == PLM_ST_READY); // [R5] [R10] [R11]
  // a selector change restarts the interval
  wire sel_changed = (sel_seen != lock_error_limit_sel);
  // last cycle of the selected interval
  wire intv_end = meas_active && !sel_changed
                  && (intv_cnt >= intv_tab[lock_error_limit_sel] - 25'd1); // [R11]
  // ppm range for the upper selector codes
  wire unit_ppm = lock_error_limit_sel[2]; // [R13]
  wire [23:0] err_ppm = meas_error_ppb / PLM_PPB_PER_PPM;
  wire [23:0] err_scaled = unit_ppm ? err_ppm : meas_error_ppb;
  // saturate into the 10-bit readback
  wire [9:0] err_sat = (err_scaled > {14'h0000, PLM_ERR_MAX}) ? PLM_ERR_MAX
                       : err_scaled[9:0]; // [R12]
  // nominal comparison; real silicon allows a quarter either side
  wire meas_locked = (meas_error_ppb <= lim_tab[lock_error_limit_sel]); // [R9]
  wire lock_change = intv_end && (meas_locked != pll_locked);
  // settle wait ends on timeout or when software asks to skip it
  wire settle_end = (state == PLM_ST_WAIT)
                    && (skip_regulator_settle_wait
                        || (settle_cnt >= 25'(SETTLE_CYC) - 25'd1)); // [R2]
  // events into the sticky status
  wire [2:0] ev_set = {settle_end, lock_change, intv_end};

  ////////////////////////////////////////////////////////////////////////////
  // startup state machine

  // next state of the regulator wait
  always_comb begin
    case (state)
      PLM_ST_WAIT: begin
        next_state = settle_end ? PLM_ST_READY : PLM_ST_WAIT; // [R2]
      end
      PLM_ST_READY: begin
        next_state = PLM_ST_READY;
      end
      default: begin
        next_state = PLM_ST_WAIT;
      end
    endcase
  end

  // state register and settle counter
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= PLM_ST_WAIT;
      settle_cnt <= 25'h000_0000;
    end else begin
      state <= next_state;
      settle_cnt <= (state == PLM_ST_WAIT) ? settle_cnt + 25'd1 : 25'h000_0000;
    end
  end

  // settled output follows the state
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_settled <= 1'b0;
    end else begin
      osc_settled <= (next_state == PLM_ST_READY);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave

  // capture the address phase of writes
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_pend <= 1'b0;
      wr_idx <= 8'h00;
    end else begin
      wr_pend <= addr_ok && hwrite;
      wr_idx <= acc_idx;
    end
  end

  // read data is ready for the data phase that follows
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_req) begin
      hrdata <= {24'h00_0000, rd_byte};
    end
  end

  // zero wait state, always okay
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  // supply register; reserved bits are not stored
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      oscillator_power_mode <= PLM_SUPPLY_RST[PLM_B_POWER]; // [R3]
      skip_regulator_settle_wait <= PLM_SUPPLY_RST[PLM_B_SKIP];
    end else if (wr_supply) begin
      oscillator_power_mode <= hwdata[PLM_B_POWER]; // [R3]
      skip_regulator_settle_wait <= hwdata[PLM_B_SKIP]; // [R2]
    end
  end

  // lock monitor control; bits act at once with no transfer strobe
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_monitor_run <= PLM_LOCKCTL_RST[PLM_B_RUN];
      lock_error_limit_sel <= PLM_LOCKCTL_RST[PLM_B_SEL_LO +: 3]; // [R8]
      lock_monitor_disable <= PLM_LOCKCTL_RST[PLM_B_DISABLE];
    end else if (wr_lockctl) begin
      lock_monitor_run <= hwdata[PLM_B_RUN]; // [R5]
      lock_error_limit_sel <= hwdata[PLM_B_SEL_LO +: 3]; // [R6] [R7]
      lock_monitor_disable <= hwdata[PLM_B_DISABLE]; // [R10]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // measurement engine

  // interval counter restarts when idle or when the selector moves
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      intv_cnt <= 25'h000_0000;
      sel_seen <= PLM_LOCKCTL_RST[PLM_B_SEL_LO +: 3];
    end else begin
      sel_seen <= lock_error_limit_sel;
      if (!meas_active || sel_changed || intv_end) begin
        intv_cnt <= 25'h000_0000; // [R11]
      end else begin
        intv_cnt <= intv_cnt + 25'd1;
      end
    end
  end

  // results latch at the end of each interval
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      freq_error_magnitude <= 10'h000;
      error_unit_select <= 1'b0;
      pll_locked <= 1'b0;
    end else if (intv_end) begin
      freq_error_magnitude <= err_sat; // [R12]
      error_unit_select <= unit_ppm; // [R13]
      pll_locked <= meas_locked; // [R15]
    end
  end

  // complete flag: set by a finished interval, cleared while idle
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_measure_complete <= 1'b0;
    end else if (intv_end) begin
      lock_measure_complete <= 1'b1; // [R14]
    end else if (!meas_active) begin
      lock_measure_complete <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts

  // sticky status per event; a set in the clearing cycle wins
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_stat
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          irq_stat[gi] <= 1'b0;
        end else if (ev_set[gi]) begin
          irq_stat[gi] <= 1'b1;
        end else if (wr_stat && hwdata[gi]) begin
          irq_stat[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // mask register, all events masked after reset
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_mask <= 3'h0;
    end else if (wr_mask) begin
      irq_mask <= hwdata[2:0];
    end
  end

  // level interrupt from the next status and mask
  wire [2:0] next_stat = ev_set | (irq_stat & ~({3{wr_stat}} & hwdata[2:0]));
  wire [2:0] next_mask = wr_mask ? hwdata[2:0] : irq_mask;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_stat & next_mask);
    end
  end

endmodule // plm_lock_monitor

// ==== plm_lock_monitor_bench.sv ====
// bench: register, startup, interrupt and lock measurement tests
`timescale 1ns/1ns
module plm_lock_monitor_bench
  import plm_pkg::*;
;
  localparam int unsigned ST = 50; // shortened settle wait
  localparam int unsigned IV [8] = '{60, 50, 40, 30, 25, 20, 1600, 410}; // intervals
  localparam logic [23:0] LIM [8] = '{PLM_LIM0, PLM_LIM1, PLM_LIM2, PLM_LIM3,
                                     PLM_LIM4, PLM_LIM5, PLM_LIM6, PLM_LIM7};
  logic core_clk, rst_b, hsel, hwrite, rd_p;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [23:0] meas;
  logic hreadyout, hresp, pwr, settled, locked, irq;
  wire logic hready;
  logic [31:0] exp_q [$]; // expected read data, oldest first
  int bad_count, num_checks, cycles, n;
  int unsigned v, e;
  assign hready = hreadyout;
  plm_lock_monitor #(.SETTLE_CYC(ST), .INTV0_CYC(IV[0]), .INTV1_CYC(IV[1]),
    .INTV2_CYC(IV[2]), .INTV3_CYC(IV[3]), .INTV4_CYC(IV[4]), .INTV5_CYC(IV[5])) i_dut (
    .core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .meas_error_ppb(meas),
    .oscillator_power_mode(pwr), .osc_settled(settled), .pll_locked(locked), .irq(irq));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  // one single transfer: address phase, then data phase
  task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge core_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rd_p <= !wr;
    do @(posedge core_clk); while (hready !== 1'b1);
    rd_p <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    bus(idx, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] x);
    exp_q.push_back(x);
    bus(idx, 1'b0, 32'h0);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // read data is compared at the edge ending the data phase
  always @(posedge core_clk) begin
    if (rd_p && hready === 1'b1) chk(hrdata, exp_q.pop_front());
    // the slave never signals an error response
    if (rd_p && hready === 1'b1) chk(32'(hresp), 32'h0);
  end
  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_b, hsel, hwrite, rd_p, htrans, haddr, hwdata, meas} = '0;
    bad_count = 0;
    num_checks = 0;
    cycles = 0;
    void'($urandom(32'hdfd2_7e79));
    tick(16);
    chk(32'(pwr), 32'h1);
    chk(32'(settled), 32'h0);
    rst_b <= 1'b1;
    tick(1);
    rd(PLM_IDX_SUPPLY, 32'h01);
    rd(PLM_IDX_LOCKCTL, 32'h0c);
    rd(PLM_IDX_IRQ_MASK, 32'h0);
    rd(8'h22, 32'h0);
    wr(PLM_IDX_SUPPLY, 32'h00);
    tick(1);
    chk(32'(pwr), 32'h0);
    rd(PLM_IDX_SUPPLY, 32'h00);
    wr(PLM_IDX_SUPPLY, 32'h01);
    $display("test reset and power mode done");
    n = 0;
    while (settled !== 1'b1 && n < ST + 10) begin
      tick(1);
      n++;
    end
    chk(32'(settled), 32'h1);
    rd(PLM_IDX_IRQ_STAT, 32'h04);
    chk(32'(irq), 32'h0);
    wr(PLM_IDX_IRQ_MASK, 32'h04);
    tick(2);
    chk(32'(irq), 32'h1);
    wr(PLM_IDX_IRQ_STAT, 32'h04);
    tick(2);
    chk(32'(irq), 32'h0);
    rd(PLM_IDX_IRQ_STAT, 32'h00);
    $display("test settle and interrupt done");
    rst_b <= 1'b0;
    tick(3);
    rst_b <= 1'b1;
    tick(1);
    wr(PLM_IDX_SUPPLY, 32'h03);
    tick(3);
    chk(32'(settled), 32'h1);
    $display("test settle skip done");
    for (int c = 0; c < 8; c++) begin
      for (int k = 0; k < 2; k++) begin
        if (k == 0) v = $urandom_range(32'(LIM[c]) * 3 / 4);
        else v = 32'(LIM[c]) * 5 / 4 + 1 + $urandom_range(32'(LIM[c]));
        e = (c >= 4) ? v / 1000 : v;
        if (e > 1023) e = 1023;
        meas <= v[23:0];
        wr(PLM_IDX_LOCKCTL, {27'h0, 1'b1, 3'(c), 1'b0});
        tick(IV[c] + 20);
        rd(PLM_IDX_ERR_LO, {24'h0, e[7:0]});
        rd(PLM_IDX_ERR_HI, {27'h0, 1'b1, c >= 4, k == 0, e[9:8]});
        chk(32'(locked), 32'(k == 0));
        wr(PLM_IDX_LOCKCTL, {27'h0, 1'b0, 3'(c), 1'b0});
        // the complete flag drops one edge after the monitor goes idle
        tick(1);
        rd(PLM_IDX_ERR_HI, {27'h0, 1'b0, c >= 4, k == 0, e[9:8]});
      end
    end
    $display("test threshold codes done");
    meas <= 24'h00_0000;
    wr(PLM_IDX_LOCKCTL, 32'h15);
    tick(IV[2] + 20);
    chk(32'(locked), 32'h0);
    rd(PLM_IDX_ERR_LO, {24'h0, e[7:0]});
    wr(PLM_IDX_LOCKCTL, 32'h14);
    tick(IV[2] + 20);
    chk(32'(locked), 32'h1);
    $display("test disable done");
    test_done();
  end
endmodule // plm_lock_monitor_bench

// ==== plm_pkg.sv ====
// package: register map, field layout, reset values and timing constants
// What this block does
// R1: software writes zeros to supply register bits 7:2
// R2: wait two seconds at startup unless skipped
// R3: power mode bit: 0 low, 1 high (reset)
// R4: software writes zeros to monitor register bits 7:5
// R5: run bit acts live, enables lock detector
// R6: codes 0-3: ppb limits, 670/170/42/10 ms
// R7: codes 4-7: ppm limits, 2.6ms down to 41us
// R8: selector resets to 110b, register to 0x0C
// R9: decision threshold tolerance is plus/minus 25 percent
// R10: disable bit set to 1 stops detector
// R11: measure while run and not disabled, per interval
// R12: 10-bit error magnitude split over two registers
// R13: bit 3 gives error unit, ppb or ppm
// R14: bit 4 flags measurement complete
// R15: bit 2 shows locked or unlocked
package plm_pkg;
  // register indices as printed, byte address is four times the index
  localparam logic [7:0] PLM_IDX_SUPPLY = 8'h1c;
  localparam logic [7:0] PLM_IDX_LOCKCTL = 8'h1d;
  localparam logic [7:0] PLM_IDX_ERR_LO = 8'h1e;
  localparam logic [7:0] PLM_IDX_ERR_HI = 8'h1f;
  localparam logic [7:0] PLM_IDX_IRQ_STAT = 8'h20;
  localparam logic [7:0] PLM_IDX_IRQ_MASK = 8'h21;
  // reset values
  localparam logic [7:0] PLM_SUPPLY_RST = 8'h01;
  localparam logic [7:0] PLM_LOCKCTL_RST = 8'h0c;
  // field positions
  localparam int PLM_B_POWER = 0;
  localparam int PLM_B_SKIP = 1;
  localparam int PLM_B_DISABLE = 0;
  localparam int PLM_B_SEL_LO = 1;
  localparam int PLM_B_RUN = 4;
  localparam int PLM_B_LOCKED = 2;
  localparam int PLM_B_UNIT = 3;
  localparam int PLM_B_DONE = 4;
  // interrupt status bits
  localparam int PLM_EV_DONE = 0;
  localparam int PLM_EV_LOCKCHG = 1;
  localparam int PLM_EV_SETTLED = 2;
  // clock rate
  localparam int unsigned PLM_CLK_PER_MS = 10_000;
  localparam int unsigned PLM_CLK_PER_US = 10;
  // regulator settle wait in seconds
  localparam int unsigned PLM_SETTLE_S = 2;
  // update intervals, codes 0-3 in ms, codes 4-7 in us
  localparam int unsigned PLM_T0_MS = 670;
  localparam int unsigned PLM_T1_MS = 170;
  localparam int unsigned PLM_T2_MS = 42;
  localparam int unsigned PLM_T3_MS = 10;
  localparam int unsigned PLM_T4_US = 2600;
  localparam int unsigned PLM_T5_US = 660;
  localparam int unsigned PLM_T6_US = 160;
  localparam int unsigned PLM_T7_US = 41;
  // error limits, codes 0-3 in ppb, codes 4-7 in ppb too (ppm times 1000)
  localparam logic [23:0] PLM_LIM0 = 24'h00_000f;
  localparam logic [23:0] PLM_LIM1 = 24'h00_003c;
  localparam logic [23:0] PLM_LIM2 = 24'h00_00ee;
  localparam logic [23:0] PLM_LIM3 = 24'h00_03ba;
  localparam logic [23:0] PLM_LIM4 = 24'h00_0ed8;
  localparam logic [23:0] PLM_LIM5 = 24'h00_3a98;
  localparam logic [23:0] PLM_LIM6 = 24'h00_ee48;
  localparam logic [23:0] PLM_LIM7 = 24'h03_b920;
  localparam logic [9:0] PLM_ERR_MAX = 10'h3ff;
  localparam logic [23:0] PLM_PPB_PER_PPM = 24'h00_03e8;
  // startup states
  typedef enum logic [1:0] {
    PLM_ST_WAIT = 2'b00,
    PLM_ST_READY = 2'b01
  } plm_state_t;
endpackage
